/* logic/hoc_pkg.sv */
// Constants for the high-impedance output shutoff controller.
// Assumes a plain register port with one-cycle read latency.
package hoc_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [1:0] CTRL_OFFSET = 2'h0;
    localparam logic [1:0] IRQ_STAT_OFFSET = 2'h1;
    localparam logic [1:0] IRQ_MASK_OFFSET = 2'h2;
    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_GATING_BIT = 6;
    localparam int CTRL_FALLING_BIT = 5;
    localparam int CTRL_RISING_BIT = 4;
    localparam int CTRL_TRIGGER_BIT = 3;
    localparam int CTRL_CLEAR_BIT = 2;
    localparam int CTRL_STATUS_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // ----------------------------------------
    // Interrupt status fields
    // ----------------------------------------
    localparam int IRQ_SHUTOFF_BIT = 0;
    localparam int IRQ_RELEASE_BIT = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int PIN_COUNT = 8;
endpackage

/* logic/hoc_shutoff.sv */
// High-impedance output shutoff controller with register port and interrupt.
// Assumes fault input is asynchronous; target pin signals come from peripherals on clk.
// How it works
// - Status flag reads 1 while pins are forced off, else 0.
// - Enable at 0 holds the status flag cleared.
// - Accepted clear write clears the flag and releases pins.
// - Accepted trigger write sets the flag and forces pins off.
// - Fault input at its abnormal level sets the flag.
// - Gating mode 1 ignores clear while fault input active.
// - Trigger acts only while fault input is inactive.
// - Both edge bits 0 ignore fault input; trigger always acts.
// - Edge pair 00 off, rising high abnormal, falling low abnormal.
// - Gating mode 0 does not block clear, but an active fault input sets the flag again in the same cycle.
// - Trigger and clear read as 0; ignored while disabled.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module hoc_shutoff (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic fault_shutoff_input,
    input wire logic [hoc_pkg::PIN_COUNT-1:0] pin_out_in,
    input wire logic [hoc_pkg::PIN_COUNT-1:0] pin_oe_in,
    output logic [hoc_pkg::PIN_COUNT-1:0] pin_out,
    output logic [hoc_pkg::PIN_COUNT-1:0] pin_oe,
    output logic hiz_active,
    output logic irq
);
    // ----------------------------------------
    // Fault input synchroniser
    // ----------------------------------------
    logic fault_meta_ff, fault_sync_ff;
    logic nxt_fault_meta, nxt_fault_sync;

    always_comb begin
        nxt_fault_meta = fault_shutoff_input;
        nxt_fault_sync = fault_meta_ff;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fault_meta_ff <= 1'b0;
            fault_sync_ff <= 1'b0;
        end else if (clk_en) begin
            fault_meta_ff <= nxt_fault_meta;
            fault_sync_ff <= nxt_fault_sync;
        end
    end

    // ----------------------------------------
    // Control state
    // ----------------------------------------
    logic hiz_control_enable_ff, clear_gating_mode_ff;
    logic falling_edge_select_ff, rising_edge_select_ff;
    logic hiz_status_flag_ff;
    logic nxt_hiz_control_enable, nxt_clear_gating_mode;
    logic nxt_falling_edge_select, nxt_rising_edge_select;
    logic nxt_hiz_status_flag;
    logic ctrl_wr, fault_active, trig_req, clr_req;

    always_comb begin
        ctrl_wr = reg_wr && (reg_addr == hoc_pkg::CTRL_OFFSET);
        // edge pair decode
        // Prohibited 11 is treated as no valid edge, so it can never latch the pins off.
        case ({falling_edge_select_ff, rising_edge_select_ff})
            2'b01: fault_active = fault_sync_ff;
            2'b10: fault_active = !fault_sync_ff;
            default: fault_active = 1'b0;
        endcase
        trig_req = ctrl_wr && reg_wdata[hoc_pkg::CTRL_TRIGGER_BIT] && hiz_control_enable_ff;
        clr_req = ctrl_wr && reg_wdata[hoc_pkg::CTRL_CLEAR_BIT] && hiz_control_enable_ff;
        nxt_hiz_control_enable = hiz_control_enable_ff;
        nxt_clear_gating_mode = clear_gating_mode_ff;
        nxt_falling_edge_select = falling_edge_select_ff;
        nxt_rising_edge_select = rising_edge_select_ff;
        if (ctrl_wr) begin
            nxt_hiz_control_enable = reg_wdata[hoc_pkg::CTRL_ENABLE_BIT];
            nxt_clear_gating_mode = reg_wdata[hoc_pkg::CTRL_GATING_BIT];
            nxt_falling_edge_select = reg_wdata[hoc_pkg::CTRL_FALLING_BIT];
            nxt_rising_edge_select = reg_wdata[hoc_pkg::CTRL_RISING_BIT];
        end
        nxt_hiz_status_flag = hiz_status_flag_ff;
        if (clr_req && !(clear_gating_mode_ff && fault_active)) begin
            nxt_hiz_status_flag = 1'b0;
        end
        // no edge means trigger always acts
        if (trig_req && !fault_active) begin
            nxt_hiz_status_flag = 1'b1;
        end
        // abnormal level sets flag; wins over a clear
        if (hiz_control_enable_ff && fault_active) begin
            nxt_hiz_status_flag = 1'b1;
        end
        if (!nxt_hiz_control_enable || !hiz_control_enable_ff) begin
            nxt_hiz_status_flag = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hiz_control_enable_ff <= 1'b0;
            clear_gating_mode_ff <= 1'b0;
            falling_edge_select_ff <= 1'b0;
            rising_edge_select_ff <= 1'b0;
            hiz_status_flag_ff <= 1'b0;
        end else if (clk_en) begin
            hiz_control_enable_ff <= nxt_hiz_control_enable;
            clear_gating_mode_ff <= nxt_clear_gating_mode;
            falling_edge_select_ff <= nxt_falling_edge_select;
            rising_edge_select_ff <= nxt_rising_edge_select;
            hiz_status_flag_ff <= nxt_hiz_status_flag;
        end
    end

    // ----------------------------------------
    // Interrupt status and mask
    // ----------------------------------------
    logic [1:0] irq_stat_ff, irq_mask_ff;
    logic [1:0] nxt_irq_stat, nxt_irq_mask;
    logic irq_ff, nxt_irq;
    logic stat_rd;

    always_comb begin
        stat_rd = reg_rd && (reg_addr == hoc_pkg::IRQ_STAT_OFFSET);
        nxt_irq_stat = stat_rd ? 2'h0 : irq_stat_ff;
        // Set wins over a read-clear in the same cycle
        if (nxt_hiz_status_flag && !hiz_status_flag_ff) begin
            nxt_irq_stat[hoc_pkg::IRQ_SHUTOFF_BIT] = 1'b1;
        end
        if (!nxt_hiz_status_flag && hiz_status_flag_ff) begin
            nxt_irq_stat[hoc_pkg::IRQ_RELEASE_BIT] = 1'b1;
        end
        nxt_irq_mask = irq_mask_ff;
        if (reg_wr && (reg_addr == hoc_pkg::IRQ_MASK_OFFSET)) begin
            nxt_irq_mask = reg_wdata[1:0];
        end
        nxt_irq = |(nxt_irq_stat & nxt_irq_mask);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_ff <= hoc_pkg::IRQ_RESET;
            irq_mask_ff <= hoc_pkg::IRQ_RESET;
            irq_ff <= 1'b0;
        end else if (clk_en) begin
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
            irq_ff <= nxt_irq;
        end
    end

    // ----------------------------------------
    // Read data and pin gating
    // ----------------------------------------
    logic [7:0] rdata_ff, nxt_rdata;
    logic [hoc_pkg::PIN_COUNT-1:0] pin_out_ff, pin_oe_ff, nxt_pin_out, nxt_pin_oe;
    logic hiz_active_ff;

    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                hoc_pkg::CTRL_OFFSET: begin
                    nxt_rdata[hoc_pkg::CTRL_ENABLE_BIT] = hiz_control_enable_ff;
                    nxt_rdata[hoc_pkg::CTRL_GATING_BIT] = clear_gating_mode_ff;
                    nxt_rdata[hoc_pkg::CTRL_FALLING_BIT] = falling_edge_select_ff;
                    nxt_rdata[hoc_pkg::CTRL_RISING_BIT] = rising_edge_select_ff;
                    nxt_rdata[hoc_pkg::CTRL_STATUS_BIT] = hiz_status_flag_ff;
                end
                hoc_pkg::IRQ_STAT_OFFSET: nxt_rdata = {6'h00, irq_stat_ff};
                hoc_pkg::IRQ_MASK_OFFSET: nxt_rdata = {6'h00, irq_mask_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
        // force enables off
        // Uses next flag so pins go quiet on the same edge the flag sets.
        nxt_pin_out = pin_out_in;
        nxt_pin_oe = nxt_hiz_status_flag ? '0 : pin_oe_in;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_ff <= 8'h00;
            pin_out_ff <= '0;
            pin_oe_ff <= '0;
            hiz_active_ff <= 1'b0;
        end else if (clk_en) begin
            rdata_ff <= nxt_rdata;
            pin_out_ff <= nxt_pin_out;
            pin_oe_ff <= nxt_pin_oe;
            hiz_active_ff <= nxt_hiz_status_flag;
        end
    end

    assign reg_rdata = rdata_ff;
    assign pin_out = pin_out_ff;
    assign pin_oe = pin_oe_ff;
    assign hiz_active = hiz_active_ff;
    assign irq = irq_ff;
endmodule
`default_nettype wire

/* tb/hoc_fault_src.sv */
// Far-side fault source: moves the fault pin to the asked level after a delay.
// Assumes the bench asks a level and then waits several cycles.
`timescale 1ns/100ps
`default_nettype none
module hoc_fault_src (
    input wire logic clk,
    input wire logic want_level,
    input wire logic [1:0] delay,
    output logic fault_shutoff_input
);
    logic [1:0] cnt = 2'h0;
    initial fault_shutoff_input = 1'b0;
    always @(posedge clk) begin
        if (want_level == fault_shutoff_input) begin
            cnt <= 2'h0;
        end else if (cnt == delay) begin
            fault_shutoff_input <= want_level;
        end else begin
            cnt <= cnt + 2'h1;
        end
    end
endmodule
`default_nettype wire

/* tb/hoc_shutoff_asserts.sv */
// Port checker for the shutoff controller.
// Assumes clk_en held high.
`timescale 1ns/100ps
`default_nettype none
module hoc_shutoff_asserts (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic fault_shutoff_input,
    input wire logic [hoc_pkg::PIN_COUNT-1:0] pin_oe_in,
    input wire logic [hoc_pkg::PIN_COUNT-1:0] pin_oe,
    input wire logic hiz_active
);
    logic [7:0] cfg_ff;
    logic [7:0] nxt_cfg;
    logic wr_ctl;
    logic abn;
    assign wr_ctl = reg_wr && reg_addr == hoc_pkg::CTRL_OFFSET;
    assign abn = cfg_ff[7] && (cfg_ff[5:4] == 2'h1 && fault_shutoff_input
        || cfg_ff[5:4] == 2'h2 && !fault_shutoff_input);
    always_comb nxt_cfg = wr_ctl ? reg_wdata : cfg_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_ff <= 8'h00;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end
    // --------
    // Checks
    // --------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Synchroniser needs three steady samples
    sequence s_abnormal;
        (abn && !reg_wr) [*3];
    endsequence
    sequence s_quiet_write;
        wr_ctl && cfg_ff[7] && reg_wdata[7] && cfg_ff[5:4] == 2'h0 && reg_wdata[5:4] == 2'h0;
    endsequence
    a_flag_read_back: assert property (reg_rd && reg_addr == hoc_pkg::CTRL_OFFSET
        |=> reg_rdata[0] == $past(hiz_active)) else $error("flag read back wrong");
    a_off_holds_clear: assert property (!cfg_ff[7] |-> !hiz_active)
        else $error("flag set while disabled");
    a_clear_releases: assert property (s_quiet_write ##0 reg_wdata[3:2] == 2'h1
        |=> !hiz_active) else $error("clear did not release");
    a_trigger_sets: assert property (s_quiet_write ##0 reg_wdata[3:2] == 2'h2
        |=> hiz_active) else $error("trigger did not set");
    a_fault_sets: assert property (s_abnormal |=> hiz_active)
        else $error("fault level did not set flag");
    a_gated_clear: assert property (s_abnormal ##1 (abn && cfg_ff[6] && wr_ctl
        && reg_wdata[7:2] == {cfg_ff[7:4], 2'h1}) |=> hiz_active) else $error("gated clear");
    a_strobes_read_zero: assert property (reg_rd && reg_addr == 2'h0
        |=> reg_rdata[3:1] == 3'h0) else $error("strobe bits read nonzero");
    a_oe_forced_off: assert property ($past(arst_n)
        |-> pin_oe == ($past(pin_oe_in) & ~{hoc_pkg::PIN_COUNT{hiz_active}}))
        else $error("output enable not forced");
endmodule
bind hoc_shutoff hoc_shutoff_asserts i_chk (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fault_shutoff_input(fault_shutoff_input), .pin_oe_in(pin_oe_in), .pin_oe(pin_oe),
    .hiz_active(hiz_active));
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench with an integer model of flag, config and irq status.
// Assumes the far side is the fault source model.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] pin_out_in = 8'h00;
    logic [7:0] pin_oe_in = 8'h00;
    logic want = 1'b0;
    logic [1:0] dly = 2'h0;
    logic fault;
    logic [7:0] reg_rdata;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic hiz_active;
    logic irq;
    int miscompares = 0, checked = 0, cyc = 0;
    int flag = 0, cfg = 0, stat = 0, mask = 0;
    always #50 clk = ~clk;
    hoc_shutoff i_dut (.clk(clk), .arst_n(arst_n), .clk_en(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .fault_shutoff_input(fault), .pin_out_in(pin_out_in), .pin_oe_in(pin_oe_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .hiz_active(hiz_active), .irq(irq));
    hoc_fault_src i_src (.clk(clk), .want_level(want), .delay(dly), .fault_shutoff_input(fault));
    task automatic summarize();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (exp !== got) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic void setf(input int v);
        if (v && !flag) stat |= 1;
        if (!v && flag) stat |= 2;
        flag = v;
    endfunction
    function automatic int abn();
        return cfg[7] && (cfg[5:4] == 1 && want || cfg[5:4] == 2 && !want);
    endfunction
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        int en0;
        en0 = cfg[7];
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a == 2) mask = d & 3;
        if (a == 0) begin
            cfg = d & 8'hF0;
            if (!d[7]) setf(0);
            else if (abn()) setf(1);
            else if (en0 && d[3]) setf(1);
            else if (en0 && d[2]) setf(0);
        end
    endtask
    task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(what, exp, reg_rdata);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            miscompares++;
            summarize();
        end
    end
    initial begin
        logic [7:0] cv;
        void'($urandom(32'h3579d9ef));
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        rd(0, 8'h00, "ctrl reset");
        wr(3, 8'hFF);
        rd(3, 8'h00, "unmapped");
        for (int i = 0; i < 40; i++) begin
            // Stimulus moves just after a rising edge, except want after a read, which ends at a falling edge
            @(posedge clk);
            cv = {1'b0, 1'($urandom), 2'($urandom_range(2)), 4'h0};
            pin_oe_in <= 8'($urandom);
            pin_out_in <= 8'($urandom);
            wr(0, 8'(cfg & 8'h70));
            // Fault moves only while disabled here, so no unmodelled events
            want <= 1'($urandom);
            dly <= 2'($urandom);
            wr(0, cv);
            repeat (6) @(posedge clk);
            wr(0, cv | 8'h80);
            rd(0, 8'(cfg | flag), "flag on enable");
            wr(0, cv | 8'h88);
            rd(0, 8'(cfg | flag), "flag after trigger");
            chk("pin_oe", flag ? 8'h00 : pin_oe_in, pin_oe);
            chk("pin_out", pin_out_in, pin_out);
            want <= 1'($urandom);
            repeat (7) @(posedge clk);
            if (abn()) setf(1);
            wr(0, cv | 8'h84);
            rd(0, 8'(cfg | flag), "flag after clear");
            @(negedge clk);
            chk("irq", {7'h0, (stat & mask) != 0}, {7'h0, irq});
            rd(1, 8'(stat), "irq status");
            stat = 0;
            wr(2, 8'($urandom));
        end
        summarize();
    end
endmodule
`default_nettype wire
